// >>> sim/gtx_fabric_model.sv
/*
 Fabric logic model supplying transmit characters.
 Assumes pclk also clocks the fabric side.
*/
module gtx_fabric_model
(
	// Clock
	input wire pclk,
	// Transmit characters
	output logic tx_write,
	output logic [31:0] tx_payload,
	output logic [3:0] tx_ctrl_flag,
	output logic [3:0] tx_disp_override,
	output logic [3:0] tx_disp_value
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		tx_write = 1'b0;
		tx_payload = 32'h0;
		tx_ctrl_flag = 4'h0;
		tx_disp_override = 4'h0;
		tx_disp_value = 4'h0;
	end
	// Writes only on pclk, locked to reference
	task send(input [31:0] p, input [3:0] k, input [3:0] o, input [3:0] v, input int n);
		@(posedge pclk);
		tx_write <= 1'b1;
		tx_payload <= p;
		tx_ctrl_flag <= k;
		tx_disp_override <= o;
		tx_disp_value <= v;
		repeat (n) @(posedge pclk);
		tx_write <= 1'b0;
		// Released data must not look valid
		tx_payload <= ~p;
	endtask
endmodule // gtx_fabric_model

// >>> sim/gtx_tx_path_monitor.sv
/*
 Checker for the transmit path ports.
 Assumes one pclk domain and presetn active low.
*/
module gtx_tx_path_monitor
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Fabric side
	input wire tx_write,
	input wire [31:0] tx_payload,
	input wire [3:0] tx_ctrl_flag,
	input wire [3:0] tx_ctrl_char_error,
	input wire tx_running_disp,
	input wire tx_fifo_overflow,
	// Line side
	input wire recovered_rx_clock,
	input wire serial_out_pos,
	input wire serial_out_neg
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [3:0] nedge;
	// Half periods up to the switch onto the reference after the no-data time may be cut
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nedge <= 4'h0;
		else if ($changed(recovered_rx_clock) && nedge != 4'hA)
			nedge <= nedge + 4'h1;
	end
	sequence s_ten_hi;
		recovered_rx_clock [*8] ##1 recovered_rx_clock [*2] ##1 !recovered_rx_clock;
	endsequence
	sequence s_ten_lo;
		!recovered_rx_clock [*8] ##1 !recovered_rx_clock [*2] ##1 recovered_rx_clock;
	endsequence
	property p_rec_hi;
		$rose(recovered_rx_clock) && nedge == 4'hA |-> s_ten_hi;
	endproperty
	property p_rec_lo;
		$fell(recovered_rx_clock) && nedge == 4'hA |-> s_ten_lo;
	endproperty
	property p_comp;
		serial_out_pos != serial_out_neg;
	endproperty
	property p_rd_init;
		$rose(presetn) |-> !tx_running_disp;
	endproperty
	property p_ovf_cause;
		tx_fifo_overflow |-> $past(tx_write);
	endproperty
	property p_kerr_cause;
		|tx_ctrl_char_error |-> $past(tx_write) && (tx_ctrl_char_error & ~$past(tx_ctrl_flag)) == 4'h0;
	endproperty
	property p_rd_cause;
		$changed(tx_running_disp) |-> $past(tx_write);
	endproperty
	property p_k_valid;
		tx_write && tx_ctrl_flag[0] && tx_payload[7:0] == 8'hBC |=> !tx_ctrl_char_error[0];
	endproperty
	a_rec_hi: assert property (p_rec_hi) else $error("recovered clock high phase");
	a_rec_lo: assert property (p_rec_lo) else $error("recovered clock low phase");
	a_comp: assert property (p_comp) else $error("serial outputs not complementary");
	a_rd_init: assert property (p_rd_init) else $error("disparity not negative at start");
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without write");
	a_kerr_cause: assert property (p_kerr_cause) else $error("control error on wrong lane");
	a_rd_cause: assert property (p_rd_cause) else $error("disparity moved without write");
	a_k_valid: assert property (p_k_valid) else $error("valid control char flagged");
endmodule // gtx_tx_path_monitor

bind gtx_tx_path gtx_tx_path_monitor i_mon (.pclk, .presetn, .tx_write, .tx_payload,
	.tx_ctrl_flag, .tx_ctrl_char_error, .tx_running_disp, .tx_fifo_overflow,
	.recovered_rx_clock, .serial_out_pos, .serial_out_neg);

// >>> sim/test_gtx_tx_path.sv
/*
 Testbench for the transmit coding path.
 Assumes APB with one wait state and a 20-cycle reference.
*/
module test_gtx_tx_path;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, tx_payload, r;
	logic [3:0] tx_ctrl_flag, tx_disp_override, tx_disp_value, tx_ctrl_char_error;
	logic pready, pslverr, tx_write, tx_running_disp, tx_fifo_overflow, tx_fifo_underflow;
	logic recovered_rx_clock, ref_locked, serial_out_pos, serial_out_neg, e, hit;
	logic tx_invert_lanes = 1'b0;
	logic [4:0] rc = 5'h00;
	logic [9:0] sh = 10'h000;
	int err_count = 0;
	int tests_run = 0;
	int ovf_n = 0;
	int unf_n = 0;
	int n0;
	wire ref_input_clock = (rc < 5'h0A);
	// Address, write, data, read data, error
	logic [73:0] arow [6] = '{{8'h00, 1'b0, 32'h0, 32'h0, 1'b0},
		{8'h00, 1'b1, 32'h1, 32'h0, 1'b0}, {8'h00, 1'b0, 32'h0, 32'h1, 1'b0},
		{8'h10, 1'b0, 32'h0, 32'h0, 1'b1}, {8'h04, 1'b0, 32'h0, 32'h40, 1'b0},
		{8'h00, 1'b1, 32'h0, 32'h0, 1'b0}};
	// Payload, flag, override, value, disparity after
	logic [11:0] frow [6] = '{{8'hBC, 4'h9}, {8'hBC, 4'h8}, {8'hB5, 4'h0},
		{8'hBC, 4'hA}, {8'hBC, 4'hD}, {8'hBC, 4'hD}};
	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		rc <= (rc == 5'h13) ? 5'h00 : rc + 5'h01;
		sh <= {sh[8:0], serial_out_pos};
		ovf_n <= ovf_n + int'(tx_fifo_overflow === 1'b1);
		unf_n <= unf_n + int'(tx_fifo_underflow === 1'b1);
	end
	gtx_tx_path i_gtx_tx_path (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .tx_write, .tx_payload, .tx_ctrl_flag, .tx_disp_override,
		.tx_disp_value, .tx_invert_lanes, .tx_ctrl_char_error, .tx_running_disp,
		.tx_fifo_overflow, .tx_fifo_underflow, .ref_input_clock, .recovered_rx_clock,
		.ref_locked, .serial_in_pos(1'b0), .serial_out_pos, .serial_out_neg);
	gtx_fabric_model i_gtx_fabric_model (.pclk, .tx_write, .tx_payload, .tx_ctrl_flag,
		.tx_disp_override, .tx_disp_value);
	task summarize;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	task apb(input [7:0] a, input w, input [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n == 50)
		begin
			err_count++;
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Bypassed char must appear override first, payload bit 0 last
	task look(input inv);
		hit = 1'b0;
		i_gtx_fabric_model.send(32'h5A, 4'h0, 4'h1, 4'h0, 1);
		repeat (60)
		begin
			@(posedge pclk);
			#1 hit = hit | (sh === ({1'b1, 1'b0, 8'h5A} ^ {10{inv}}));
		end
		chk("bypass_order", 1, hit);
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		chk("neg_in_reset", 1, serial_out_neg);
		chk("rd_in_reset", 0, tx_running_disp);
		chk("lock_in_reset", 0, ref_locked);
		presetn <= 1'b1;
		repeat (60) @(posedge pclk);
		chk("ref_locked", 1, ref_locked);
		foreach (arow[i])
		begin
			apb(arow[i][73:66], arow[i][65], arow[i][64:33]);
			chk("apb_rdata", arow[i][32:1], r);
			chk("apb_err", arow[i][0], e);
		end
		foreach (frow[i])
		begin
			i_gtx_fabric_model.send(frow[i][11:4], frow[i][3], frow[i][2], frow[i][1], 1);
			#1 chk("run_disp", frow[i][0], tx_running_disp);
			chk("kerr", 0, tx_ctrl_char_error);
			repeat (12) @(posedge pclk);
		end
		apb(8'h00, 1'b1, 32'h1);
		i_gtx_fabric_model.send(32'h00BC, 4'h3, 4'h0, 4'h0, 1);
		#1 chk("kerr_lane1", 4'h2, tx_ctrl_char_error);
		apb(8'h00, 1'b1, 32'h4);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge pclk);
			tx_invert_lanes <= j[0];
			look(j[0]);
		end
		for (int j = 0; j < 2; j++)
		begin
			apb(8'h00, 1'b1, j ? 32'h0 : 32'h8);
			repeat (60) @(posedge pclk);
			n0 = ovf_n;
			i_gtx_fabric_model.send(32'hB5B5B5B5, 4'h0, 4'h0, 4'h0, 6);
			repeat (3) @(posedge pclk);
			chk("ovf_count", 1, (ovf_n - n0) inside {[(j ? 1 : 4) : (j ? 2 : 5)]});
		end
		// Refused writes leave sticky overflow set; writing one clears it
		apb(8'h04, 1'b0, 32'h0);
		chk("sticky_ovf", 32'h2, r & 32'h2);
		apb(8'h04, 1'b1, 32'h2);
		apb(8'h04, 1'b0, 32'h0);
		chk("sticky_clear", 32'h0, r & 32'h2);
		// Four lanes: forced K-, K+, K-, then balanced data keeps positive
		apb(8'h00, 1'b1, 32'h2);
		repeat (60) @(posedge pclk);
		i_gtx_fabric_model.send(32'hB5BCBCBC, 4'h7, 4'h1, 4'h0, 1);
		#1 chk("rd_four_lanes", 1, tx_running_disp);
		repeat (60) @(posedge pclk);
		chk("underflow", 1, unf_n > 0);
		summarize();
	end
endmodule // test_gtx_tx_path

// >>> verilog/gtx_regs.vh
/*
 Register map, field positions, reset values, code tables and timing counts
 for the transmit coding path. Assumes inclusion by bare name from the
 design file; definitions only.
*/
`ifndef GTX_REGS_VH
`define GTX_REGS_VH

// APB map
`define GTX_CTRL_ADDR 8'h00
`define GTX_STAT_ADDR 8'h04
`define GTX_CTRL_RESET 4'h0

// Control fields
`define GTX_CTRL_WIDTH 1:0
`define GTX_CTRL_ENC_BYP 2
`define GTX_CTRL_FIFO_BYP 3

// Status fields
`define GTX_ST_RD 0
`define GTX_ST_OVF 1
`define GTX_ST_UNF 2
`define GTX_ST_LVL 5:3
`define GTX_ST_LOCK 6
`define GTX_ST_CDR 7

// Width codes and stored lane counts (lanes minus one)
`define GTX_W1 2'h0
`define GTX_W2 2'h1
`define GTX_LANES1 2'h0
`define GTX_LANES2 2'h1
`define GTX_LANES4 2'h3

// Serial timing, in bit times (one pclk per bit)
`define GTX_BITS_PER_REF 20
`define GTX_LAST_BIT 5'h13
`define GTX_HALF_LAST 5'h09
`define GTX_RX_HALF 5'h0A
`define GTX_RX_EDGE_PHASE 5'h01
`define GTX_NO_DATA_BITS 7'h4C

// Transmit FIFO
`define GTX_FIFO_DEPTH 3'h4
`define GTX_FIFO_BYP_DEPTH 3'h1

// 8b/10b tables, minus-disparity column, abcdei / fghj with a leftmost
`define GTX_TBL6 {6'h2B,6'h1E,6'h2E,6'h0E,6'h36,6'h16,6'h26,6'h33,6'h3A,6'h1A,6'h2A,6'h0B,\
6'h32,6'h13,6'h23,6'h1B,6'h17,6'h1C,6'h2C,6'h0D,6'h34,6'h15,6'h25,6'h39,6'h38,6'h19,6'h29,\
6'h35,6'h31,6'h2D,6'h1D,6'h27}
`define GTX_TBL4 {4'hE,4'h6,4'hA,4'hD,4'hC,4'h5,4'h9,4'hB}
`define GTX_K28_6B 6'h0F
`define GTX_D7_6B 6'h38
`define GTX_A7_4B 4'h7

// Idle comma sent on underflow, first-sent bit at bit 0
`define GTX_IDLE_SYM 10'h17C

`endif

// >>> verilog/gtx_tx_path.v
/*
 Transmit coding path of a serial transceiver: per-lane 8b/10b encoder with
 disparity control, four-entry transmit FIFO, 20-bit serializer, reference
 lock and recovered clock, APB configuration and status.
 Assumes pclk is the serial bit clock and all inputs are synchronous to it;
 ref_input_clock is a sampled level with a period of twenty pclk cycles.
*/
// The address map and the APB slave port were decided locally.
`include "gtx_regs.vh"

module gtx_tx_path
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Fabric transmit interface, lane 0 sent first
	input wire tx_write,
	input wire [31:0] tx_payload,
	input wire [3:0] tx_ctrl_flag,
	input wire [3:0] tx_disp_override,
	input wire [3:0] tx_disp_value,
	input wire tx_invert_lanes,
	output reg [3:0] tx_ctrl_char_error,
	output reg tx_running_disp,
	output reg tx_fifo_overflow,
	output reg tx_fifo_underflow,
	// Clocking
	input wire ref_input_clock,
	output reg recovered_rx_clock,
	output reg ref_locked,
	// Serial line
	input wire serial_in_pos,
	output reg serial_out_pos,
	output reg serial_out_neg
);

localparam [191:0] TBL6 = `GTX_TBL6;
localparam [31:0] TBL4 = `GTX_TBL4;

function [3:0] gtx_ones;
	input [9:0] v;
	integer n;
	begin
		gtx_ones = 4'h0;
		for (n = 0; n < 10; n = n + 1)
			gtx_ones = gtx_ones + {3'h0, v[n]};
	end
endfunction

// Puts the first-sent bit at index 0
function [9:0] gtx_rev;
	input [9:0] v;
	integer n;
	begin
		for (n = 0; n < 10; n = n + 1)
			gtx_rev[n] = v[9 - n];
	end
endfunction

function gtx_kvalid;
	input [7:0] d;
	begin
		gtx_kvalid = (d[4:0] == 5'h1C) || (d[7:5] == 3'h7 && (d[4:0] == 5'h17
			|| d[4:0] == 5'h1B || d[4:0] == 5'h1D || d[4:0] == 5'h1E));
	end
endfunction

// Returns {disparity after, symbol}; rd high means positive
function [10:0] gtx_enc;
	input [7:0] d;
	input k;
	input rd;
	reg [5:0] m6;
	reg [5:0] c6;
	reg [3:0] m4;
	reg [3:0] p4;
	reg [3:0] c4;
	reg rd6;
	reg a7;
	begin
		m6 = TBL6[d[4:0] * 6 +: 6];
		if (k && d[4:0] == 5'h1C)
			m6 = `GTX_K28_6B;
		c6 = (rd && (gtx_ones({4'h0, m6}) != 4'h3 || m6 == `GTX_D7_6B)) ? ~m6 : m6;
		rd6 = rd ^ (gtx_ones({4'h0, c6}) != 4'h3);
		// Alternate 4b code avoids a run of five equal bits
		a7 = d[7:5] == 3'h7 && (k
			|| (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
			|| (rd6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
		m4 = a7 ? `GTX_A7_4B : TBL4[d[7:5] * 4 +: 4];
		p4 = (gtx_ones({6'h00, m4}) != 4'h2 || d[7:5] == 3'h3) ? ~m4 : m4;
		if (k)
			c4 = rd ? ~p4 : p4;
		else
			c4 = rd6 ? p4 : m4;
		gtx_enc[9:0] = gtx_rev({c6, c4});
		gtx_enc[10] = rd ^ (gtx_ones({c6, c4}) != 4'h5);
	end
endfunction

// Configuration and status
reg [3:0] ctrl;
reg sticky_ovf;
reg sticky_unf;
wire [1:0] lanes;
wire enc_bypass;
wire fifo_bypass;

// Encoder state
reg enc_rd;
reg [39:0] next_syms;
reg [3:0] next_kerr;
reg next_rd;
reg rd_c;
reg rd_use;
reg [10:0] enc;
integer i;

// FIFO
reg [39:0] fifo_sym [0:3];
reg [1:0] fifo_nl [0:3];
reg [1:0] wr_ptr;
reg [1:0] rd_ptr;
reg [2:0] level;
reg [1:0] lane_idx;
reg primed;
wire [2:0] cap;
wire push;
wire ovf;
wire refill;
wire pop_sym;
wire pop_entry;
wire [9:0] cur_sym;

// Serializer and clocking
reg [19:0] word;
reg [4:0] bit_cnt;
reg [4:0] ref_per;
reg ref_q;
reg rx_q;
reg [4:0] rx_cnt;
reg [6:0] rx_quiet;
wire ref_rise;
wire rx_edge;
wire rx_idle;
wire [4:0] bit_next;
wire apb_wr;
wire apb_rd;

assign lanes = (ctrl[`GTX_CTRL_WIDTH] == `GTX_W1) ? `GTX_LANES1 :
	(ctrl[`GTX_CTRL_WIDTH] == `GTX_W2) ? `GTX_LANES2 : `GTX_LANES4;
assign enc_bypass = ctrl[`GTX_CTRL_ENC_BYP];
assign fifo_bypass = ctrl[`GTX_CTRL_FIFO_BYP];

// FIFO bypass leaves a single holding stage
assign cap = fifo_bypass ? `GTX_FIFO_BYP_DEPTH : `GTX_FIFO_DEPTH;
assign push = tx_write && (level < cap);
assign ovf = tx_write && !(level < cap);

assign refill = (bit_cnt == `GTX_HALF_LAST) || (bit_cnt == `GTX_LAST_BIT);
assign pop_sym = refill && (level != 3'h0);
assign pop_entry = pop_sym && (lane_idx == fifo_nl[rd_ptr]);
assign cur_sym = fifo_sym[rd_ptr][lane_idx * 10 +: 10];

assign ref_rise = ref_input_clock && !ref_q;
assign rx_edge = serial_in_pos ^ rx_q;
assign rx_idle = (rx_quiet == `GTX_NO_DATA_BITS);
assign bit_next = (bit_cnt == `GTX_LAST_BIT) ? 5'h00 : bit_cnt + 5'h01;

// Writes land at the edge where the master sees pready; read data is staged one edge earlier
assign apb_wr = psel && penable && pwrite && pready;
assign apb_rd = psel && penable && !pwrite && !pready;

// Encode each lane up to the configured width; disparity carries into the next lane
always @*
begin
	next_syms = 40'h0;
	next_kerr = 4'h0;
	rd_c = enc_rd;
	rd_use = 1'b0;
	enc = 11'h000;
	for (i = 0; i < 4; i = i + 1)
	begin
		if (i <= lanes)
		begin
			rd_use = tx_disp_override[i] ? tx_disp_value[i] : (rd_c ^ tx_disp_value[i]);
			enc = gtx_enc(tx_payload[i * 8 +: 8], tx_ctrl_flag[i], rd_use);
			if (enc_bypass)
			begin
				next_syms[i * 10 +: 10] = gtx_rev({tx_disp_override[i], tx_disp_value[i],
					tx_payload[i * 8 +: 8]});
			end
			else
			begin
				next_syms[i * 10 +: 10] = enc[9:0];
				rd_c = enc[10];
				next_kerr[i] = tx_ctrl_flag[i] && !gtx_kvalid(tx_payload[i * 8 +: 8]);
			end
		end
	end
	next_rd = rd_c;
end

// APB slave: one wait state, pready always from a flop
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ctrl <= `GTX_CTRL_RESET;
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end
	else
	begin
		pready <= psel && penable && !pready;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
		if (apb_wr && paddr == `GTX_CTRL_ADDR)
			ctrl <= pwdata[3:0];
		if (apb_rd && paddr == `GTX_CTRL_ADDR)
			prdata <= {28'h0000000, ctrl};
		if (apb_rd && paddr == `GTX_STAT_ADDR)
			prdata <= {24'h000000, rx_idle == 1'b0, ref_locked, level,
				sticky_unf, sticky_ovf, enc_rd};
		if (psel && penable && !pready && paddr != `GTX_CTRL_ADDR && paddr != `GTX_STAT_ADDR)
			pslverr <= 1'b1;
	end
end

// Sticky flags: write one clears, a new event in the same cycle wins
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		sticky_ovf <= 1'b0;
		sticky_unf <= 1'b0;
	end
	else
	begin
		if (apb_wr && paddr == `GTX_STAT_ADDR && pwdata[`GTX_ST_OVF])
			sticky_ovf <= 1'b0;
		if (apb_wr && paddr == `GTX_STAT_ADDR && pwdata[`GTX_ST_UNF])
			sticky_unf <= 1'b0;
		if (ovf)
			sticky_ovf <= 1'b1;
		if (refill && level == 3'h0 && primed)
			sticky_unf <= 1'b1;
	end
end

// Encoder disparity and fabric-side reports
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		enc_rd <= 1'b0;
		tx_running_disp <= 1'b0;
		tx_ctrl_char_error <= 4'h0;
		tx_fifo_overflow <= 1'b0;
		tx_fifo_underflow <= 1'b0;
	end
	else
	begin
		// Disparity advances only for characters that enter the FIFO
		if (push)
			enc_rd <= next_rd;
		tx_running_disp <= push ? next_rd : enc_rd;
		tx_ctrl_char_error <= tx_write ? next_kerr : 4'h0;
		tx_fifo_overflow <= ovf;
		tx_fifo_underflow <= refill && level == 3'h0 && primed;
	end
end

always @(posedge pclk)
begin
	if (push)
	begin
		fifo_sym[wr_ptr] <= next_syms;
		fifo_nl[wr_ptr] <= lanes;
	end
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		wr_ptr <= 2'h0;
		rd_ptr <= 2'h0;
		level <= 3'h0;
		lane_idx <= 2'h0;
		primed <= 1'b0;
	end
	else
	begin
		if (push)
			wr_ptr <= wr_ptr + 2'h1;
		if (pop_entry)
			rd_ptr <= rd_ptr + 2'h1;
		if (pop_sym)
			lane_idx <= pop_entry ? 2'h0 : lane_idx + 2'h1;
		level <= level + {2'h0, push} - {2'h0, pop_entry};
		// Underflow counts only after traffic started, not at idle power-up
		if (push)
			primed <= 1'b1;
		else if (refill && level == 3'h0)
			primed <= 1'b0;
	end
end

// Serializer and reference lock
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		word <= {`GTX_IDLE_SYM, `GTX_IDLE_SYM};
		bit_cnt <= 5'h00;
		ref_per <= 5'h00;
		ref_q <= 1'b0;
		ref_locked <= 1'b0;
		serial_out_pos <= 1'b0;
		serial_out_neg <= 1'b1;
	end
	else
	begin
		ref_q <= ref_input_clock;
		// word boundary follows each rising reference edge
		if (ref_rise)
		begin
			bit_cnt <= 5'h00;
			ref_per <= 5'h00;
			ref_locked <= (ref_per == `GTX_LAST_BIT);
		end
		else
		begin
			bit_cnt <= bit_next;
			ref_per <= (ref_per == 5'h1F) ? ref_per : ref_per + 5'h01;
			if (ref_per == 5'h1F)
				ref_locked <= 1'b0;
		end
		// Refill the half already sent; the idle comma ignores disparity
		if (bit_cnt == `GTX_HALF_LAST)
			word[9:0] <= pop_sym ? cur_sym : `GTX_IDLE_SYM;
		if (bit_cnt == `GTX_LAST_BIT)
			word[19:10] <= pop_sym ? cur_sym : `GTX_IDLE_SYM;
		serial_out_pos <= word[bit_cnt] ^ tx_invert_lanes;
		serial_out_neg <= ~(word[bit_cnt] ^ tx_invert_lanes);
	end
end

// Recovered clock
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		rx_q <= 1'b0;
		rx_cnt <= 5'h00;
		rx_quiet <= 7'h00;
		recovered_rx_clock <= 1'b0;
	end
	else
	begin
		rx_q <= serial_in_pos;
		if (rx_edge)
			rx_quiet <= 7'h00;
		else if (!rx_idle)
			rx_quiet <= rx_quiet + 7'h01;
		if (rx_edge)
			rx_cnt <= `GTX_RX_EDGE_PHASE;
		else if (rx_idle)
			rx_cnt <= ref_rise ? 5'h01 : bit_next;
		else
			rx_cnt <= (rx_cnt == `GTX_LAST_BIT) ? 5'h00 : rx_cnt + 5'h01;
		// one twentieth of the bit rate
		recovered_rx_clock <= (rx_cnt < `GTX_RX_HALF);
	end
end

endmodule // gtx_tx_path
